// *** shared/isam_pkg.sv ***
// Constants and types for the ISA bus master cycle sequencer
`default_nettype none
package isam_pkg;
   // Core clock and derived bus clock
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned BCLK_PERIOD_NS = 128;
   localparam int unsigned BCLK_DIV = (BCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_W = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_DIV - 1);
   localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(BCLK_DIV / 2);

   // Bus-clock counts in T; all but the CNT_W width and the CNT_MAX saturation ceiling are minimums
   localparam int unsigned CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;
   localparam logic [CNT_W-1:0] LA_TO_ALE_NEG = 5'h05;
   localparam logic [CNT_W-1:0] LA_TO_CMD = 5'h05;
   localparam logic [CNT_W-1:0] SA_TO_ALE_NEG = 5'h01;
   localparam logic [CNT_W-1:0] SA_TO_CMD = 5'h02;
   localparam logic [CNT_W-1:0] CMD_WIDTH = 5'h09;
   localparam logic [CNT_W-1:0] CMD_TO_ALE = 5'h0A;
   localparam logic [CNT_W-1:0] CMD_TO_CMD = 5'h0C;
   localparam logic [CNT_W-1:0] NEG_TO_CMD = 5'h03;
   localparam logic [CNT_W-1:0] NEG_TO_ALE = 5'h01;
   localparam logic [CNT_W-1:0] CMD_TO_RD_16 = 5'h02;
   localparam logic [CNT_W-1:0] CMD_TO_RD_8 = 5'h05;
   localparam logic [CNT_W-1:0] RDY_TO_RD = 5'h01;
   localparam logic [CNT_W-1:0] RDY_TO_WR = 5'h02;
   localparam logic [CNT_W-1:0] RDY_TO_NEG = 5'h01;
   localparam logic [CNT_W-1:0] RDY_TO_ALE = 5'h02;
   localparam logic [CNT_W-1:0] SA_TO_RDY_16 = 5'h06;
   localparam logic [CNT_W-1:0] SA_TO_RDY_8 = 5'h0C;
   localparam logic [CNT_W-1:0] SA_TO_RD_16 = 5'h04;
   localparam logic [CNT_W-1:0] SA_TO_RD_8 = 5'h0A;
   localparam logic [CNT_W-1:0] LA_TO_RDY_16 = 5'h08;
   localparam logic [CNT_W-1:0] LA_TO_RDY_8 = 5'h0E;
   localparam logic [CNT_W-1:0] WDATA_TO_CMD = 5'h02;
   localparam logic [CNT_W-1:0] WDATA_HOLD = 5'h01;

   // Command classes
   localparam logic [1:0] CLS_MEM = 2'h0;
   localparam logic [1:0] CLS_SMEM = 2'h1;
   localparam logic [1:0] CLS_IO = 2'h2;

   // Reset values
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic [23:0] ADDR_RST = 24'h000000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WAIT  = 3'b001,
      ST_ADDR  = 3'b010,
      ST_SETUP = 3'b011,
      ST_CMD   = 3'b100
   } isam_state_t;
endpackage
`default_nettype wire

// *** design/isam_master.sv ***
// ISA bus master cycle sequencer: address, latch strobe, command and wait timing
// Functional notes
// - Upper address valid 5T before ALE negate, 6T before command
// - SA/SBHE 1T before ALE negate, 2T before command
// - Command strobe held at least 9T
// - 10T from command assert to next ALE
// - Same class commands spaced at least 12T
// - 3T from command negate to next command
// - Command negated 2T before next ALE
// - Read sample 2T/5T after read command
// - Data 1T after ready for reads, 2T writes
// - Negate command at least 1T after ready
// - Next ALE 2T after ready; address held
// - SA valid 6T/12T before ready negation counts
// - Read sample 4T/10T after system address
// - Upper address 8T/14T before ready negation counts
// - Write data driven 2T before write command
`default_nettype none
module isam_master (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Request side
   input  wire logic        reqValid,
   input  wire logic        reqWrite,
   input  wire logic [1:0]  reqClass,
   input  wire logic        reqByte,
   input  wire logic [23:0] reqAddr,
   input  wire logic        reqSbhe,
   input  wire logic [15:0] reqWdata,
   output logic             reqReady,
   // Answer side
   output logic             rspValid,
   output logic [15:0]      rspData,
   // ISA bus pins
   output logic             busClk,
   output logic [6:0]       latchAddr,
   output logic [19:0]      sysAddr,
   output logic             sysBhe,
   output logic             addrLatchN,
   output logic             memRdN,
   output logic             memWrN,
   output logic             smemRdN,
   output logic             smemWrN,
   output logic             ioRdN,
   output logic             ioWrN,
   input  wire logic        chanRdy,
   input  wire logic [15:0] dataIn,
   output logic [15:0]      dataOut,
   output logic             dataOe
);

   // Saturating increment: the elapsed count as seen at this bus tick
   function automatic logic [isam_pkg::CNT_W-1:0] satInc(input logic [isam_pkg::CNT_W-1:0] c);
      satInc = (c == isam_pkg::CNT_MAX) ? c : c + 5'h01;
   endfunction
   isam_pkg::isam_state_t        state_q;
   logic [isam_pkg::DIV_W-1:0]   div_q;
   logic                         tick;
   logic                         rdyMeta_q;
   logic                         rdySync_q;
   logic [15:0]                  dinMeta_q;
   logic [15:0]                  dinSync_q;
   logic [isam_pkg::CNT_W-1:0]   addrCnt_q;
   logic [isam_pkg::CNT_W-1:0]   cmdCnt_q;
   logic [isam_pkg::CNT_W-1:0]   negCnt_q;
   logic [isam_pkg::CNT_W-1:0]   rdyCnt_q;
   logic [isam_pkg::CNT_W-1:0]   clsCnt_q [3];
   logic                         curWrite_q;
   logic [1:0]                   curClass_q;
   logic                         curByte_q;
   logic [23:0]                  curAddr_q;
   logic                         curSbhe_q;
   logic [15:0]                  curWdata_q;
   logic [isam_pkg::CNT_W-1:0]   addrEl;
   logic [isam_pkg::CNT_W-1:0]   cmdEl;
   logic                         startOk;
   logic                         cmdOk;
   logic                         negOk;
   logic                         wdataOk;

   // Bus clock from the core clock; every bus event happens at its rising edge
   assign tick = (div_q == isam_pkg::DIV_LAST);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_q <= '0;
         busClk <= 1'b0;
      end else begin
         div_q <= tick ? '0 : div_q + 4'h1;
         busClk <= (div_q == isam_pkg::DIV_LAST) || (div_q < isam_pkg::DIV_HALF - 4'h1);
      end
   end

   // Pin synchronisers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdyMeta_q <= 1'b0;
         rdySync_q <= 1'b0;
         dinMeta_q <= isam_pkg::DATA_RST;
         dinSync_q <= isam_pkg::DATA_RST;
      end else begin
         rdyMeta_q <= chanRdy;
         rdySync_q <= rdyMeta_q;
         dinMeta_q <= dataIn;
         dinSync_q <= dinMeta_q;
      end
   end
   assign addrEl = satInc(addrCnt_q);
   assign cmdEl = satInc(cmdCnt_q);
   // Gap since the previous cycle before a new latch strobe
   assign startOk = (satInc(cmdCnt_q) >= isam_pkg::CMD_TO_ALE)
                 && (satInc(negCnt_q) > isam_pkg::NEG_TO_ALE)
                 && (satInc(rdyCnt_q) > isam_pkg::RDY_TO_ALE);
   assign wdataOk = !curWrite_q || (addrEl >= isam_pkg::WDATA_TO_CMD);
   assign cmdOk = (addrEl > isam_pkg::LA_TO_CMD)
               && (addrEl >= isam_pkg::SA_TO_CMD)
               && wdataOk
               && (satInc(negCnt_q) >= isam_pkg::NEG_TO_CMD)
               && (satInc(clsCnt_q[curClass_q]) >= isam_pkg::CMD_TO_CMD);

   // Ready only ends the cycle once every address and data window is met
   always_comb begin
      negOk = rdySync_q && (cmdEl >= isam_pkg::CMD_WIDTH)
           && (rdyCnt_q >= isam_pkg::RDY_TO_NEG);
      if (curByte_q) begin
         negOk = negOk && (addrEl >= isam_pkg::SA_TO_RDY_8)
                 && (addrEl >= isam_pkg::LA_TO_RDY_8)
                 && (curWrite_q || (cmdEl >= isam_pkg::CMD_TO_RD_8
                     && addrEl >= isam_pkg::SA_TO_RD_8));
      end else begin
         negOk = negOk && (addrEl >= isam_pkg::SA_TO_RDY_16)
                 && (addrEl >= isam_pkg::LA_TO_RDY_16)
                 && (curWrite_q || (cmdEl >= isam_pkg::CMD_TO_RD_16
                     && addrEl >= isam_pkg::SA_TO_RD_16));
      end
      if (curWrite_q) begin
         negOk = negOk && (rdyCnt_q >= isam_pkg::RDY_TO_WR);
      end else begin
         negOk = negOk && (rdyCnt_q >= isam_pkg::RDY_TO_RD);
      end
   end

   // Cycle state machine and request capture
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= isam_pkg::ST_IDLE;
         reqReady <= 1'b0;
         curWrite_q <= 1'b0;
         curClass_q <= isam_pkg::CLS_MEM;
         curByte_q <= 1'b0;
         curAddr_q <= isam_pkg::ADDR_RST;
         curSbhe_q <= 1'b0;
         curWdata_q <= isam_pkg::DATA_RST;
      end else begin
         case (state_q)
            isam_pkg::ST_IDLE: begin
               reqReady <= 1'b1;
               if (reqValid && reqReady) begin
                  reqReady <= 1'b0;
                  curWrite_q <= reqWrite;
                  curClass_q <= reqClass;
                  curByte_q <= reqByte;
                  curAddr_q <= reqAddr;
                  curSbhe_q <= reqSbhe;
                  curWdata_q <= reqWdata;
                  state_q <= isam_pkg::ST_WAIT;
               end
            end
            isam_pkg::ST_WAIT: begin
               if (tick && startOk) begin
                  state_q <= isam_pkg::ST_ADDR;
               end
            end
            isam_pkg::ST_ADDR: begin
               if (tick && addrEl >= isam_pkg::LA_TO_ALE_NEG
                   && addrEl >= isam_pkg::SA_TO_ALE_NEG) begin
                  state_q <= isam_pkg::ST_SETUP;
               end
            end
            isam_pkg::ST_SETUP: begin
               if (tick && cmdOk) begin
                  state_q <= isam_pkg::ST_CMD;
               end
            end
            isam_pkg::ST_CMD: begin
               if (tick && negOk) begin
                  state_q <= isam_pkg::ST_IDLE;
               end
            end
            default: state_q <= isam_pkg::ST_IDLE;
         endcase
      end
   end

   // Bus-clock counters; all saturate so long idle periods stay satisfied
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addrCnt_q <= isam_pkg::CNT_MAX;
         cmdCnt_q <= isam_pkg::CNT_MAX;
         negCnt_q <= isam_pkg::CNT_MAX;
         rdyCnt_q <= isam_pkg::CNT_MAX;
         for (int i = 0; i < 3; i++) begin
            clsCnt_q[i] <= isam_pkg::CNT_MAX;
         end
      end else if (tick) begin
         addrCnt_q <= (state_q == isam_pkg::ST_WAIT && startOk) ? '0 : addrEl;
         cmdCnt_q <= (state_q == isam_pkg::ST_SETUP && cmdOk) ? '0 : cmdEl;
         negCnt_q <= (state_q == isam_pkg::ST_CMD && negOk) ? '0 : satInc(negCnt_q);
         if (state_q == isam_pkg::ST_CMD) begin
            rdyCnt_q <= rdySync_q ? satInc(rdyCnt_q) : '0;
         end else if (state_q == isam_pkg::ST_SETUP && cmdOk) begin
            rdyCnt_q <= '0;
         end else begin
            rdyCnt_q <= satInc(rdyCnt_q);
         end
         for (int i = 0; i < 3; i++) begin
            clsCnt_q[i] <= (state_q == isam_pkg::ST_SETUP && cmdOk && curClass_q == 2'(i))
                         ? '0 : satInc(clsCnt_q[i]);
         end
      end
   end

   // Pins change only on bus ticks; addresses hold until the next cycle starts
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addrLatchN <= 1'b1;
         latchAddr <= '0;
         sysAddr <= '0;
         sysBhe <= 1'b0;
         dataOut <= isam_pkg::DATA_RST;
         dataOe <= 1'b0;
      end else if (tick) begin
         if (state_q == isam_pkg::ST_WAIT && startOk) begin
            addrLatchN <= 1'b0;
            latchAddr <= curAddr_q[23:17];
            sysAddr <= curAddr_q[19:0];
            sysBhe <= curSbhe_q;
            dataOut <= curWdata_q;
            dataOe <= curWrite_q;
         end else begin
            if (state_q == isam_pkg::ST_ADDR && addrEl >= isam_pkg::LA_TO_ALE_NEG) begin
               addrLatchN <= 1'b1;
            end
            // Write data lingers past the strobe so the slave sees a clean hold
            if (state_q != isam_pkg::ST_CMD && state_q != isam_pkg::ST_SETUP
                && state_q != isam_pkg::ST_ADDR && negCnt_q >= isam_pkg::WDATA_HOLD) begin
               dataOe <= 1'b0;
            end
         end
      end
   end

   // Command strobes, one per class and direction
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         memRdN <= 1'b1;
         memWrN <= 1'b1;
         smemRdN <= 1'b1;
         smemWrN <= 1'b1;
         ioRdN <= 1'b1;
         ioWrN <= 1'b1;
      end else if (tick) begin
         if (state_q == isam_pkg::ST_SETUP && cmdOk) begin
            memRdN <= !(curClass_q == isam_pkg::CLS_MEM && !curWrite_q);
            memWrN <= !(curClass_q == isam_pkg::CLS_MEM && curWrite_q);
            smemRdN <= !(curClass_q == isam_pkg::CLS_SMEM && !curWrite_q);
            smemWrN <= !(curClass_q == isam_pkg::CLS_SMEM && curWrite_q);
            ioRdN <= !(curClass_q == isam_pkg::CLS_IO && !curWrite_q);
            ioWrN <= !(curClass_q == isam_pkg::CLS_IO && curWrite_q);
         end else if (state_q == isam_pkg::ST_CMD && negOk) begin
            memRdN <= 1'b1;
            memWrN <= 1'b1;
            smemRdN <= 1'b1;
            smemWrN <= 1'b1;
            ioRdN <= 1'b1;
            ioWrN <= 1'b1;
         end
      end
   end

   // Read data taken at the negating edge; the slave may float right after
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rspValid <= 1'b0;
         rspData <= isam_pkg::DATA_RST;
      end else begin
         rspValid <= tick && state_q == isam_pkg::ST_CMD && negOk;
         if (tick && state_q == isam_pkg::ST_CMD && negOk && !curWrite_q) begin
            rspData <= dinSync_q;
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/isam_master_properties.sv ***
// Bus timing checker for the ISA master sequencer, bound to its top module
`default_nettype none
module isam_master_properties (
   // Clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // Bus pins
   input wire logic [6:0]  latchAddr,
   input wire logic [19:0] sysAddr,
   input wire logic        sysBhe,
   input wire logic        addrLatchN,
   input wire logic        memRdN,
   input wire logic        memWrN,
   input wire logic        smemRdN,
   input wire logic        smemWrN,
   input wire logic        ioRdN,
   input wire logic        ioWrN,
   input wire logic        chanRdy,
   input wire logic        dataOe,
   // Answer and bus clock
   input wire logic        rspValid,
   input wire logic        busClk
);
   logic       cmdLow;
   logic       wrLow;
   logic [8:0] cmdLen_q;
   logic [8:0] sinceCmd_q;
   logic [8:0] sinceNeg_q;
   logic [8:0] sinceAle_q;
   logic [8:0] rdyCnt_q;
   logic [8:0] sinceOe_q;
   assign cmdLow = ~(memRdN & memWrN & smemRdN & smemWrN & ioRdN & ioWrN);
   assign wrLow = ~(memWrN & smemWrN);
   function automatic logic [8:0] sat(input logic [8:0] v);
      return (v == 9'h1FF) ? v : v + 9'h001;
   endfunction
   // Gaps start saturated: the first cycle after reset owes no spacing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmdLen_q <= 9'h000;
         sinceCmd_q <= 9'h1FF;
         sinceNeg_q <= 9'h1FF;
         sinceAle_q <= 9'h1FF;
         rdyCnt_q <= 9'h000;
         sinceOe_q <= 9'h000;
      end else begin
         cmdLen_q <= cmdLow ? sat(cmdLen_q) : 9'h000;
         sinceCmd_q <= $rose(cmdLow) ? 9'h001 : sat(sinceCmd_q);
         sinceNeg_q <= $fell(cmdLow) ? 9'h001 : sat(sinceNeg_q);
         sinceAle_q <= $fell(addrLatchN) ? 9'h001 : sat(sinceAle_q);
         rdyCnt_q <= chanRdy ? sat(rdyCnt_q) : 9'h000;
         sinceOe_q <= dataOe ? sat(sinceOe_q) : 9'h000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // One bus clock is 16 core clocks
   a_cmd_min_width: assert property (
      $fell(cmdLow) |-> cmdLen_q >= 9'h090) else $error("command too short");
   a_cmd_to_ale: assert property (
      $fell(addrLatchN) |-> sinceCmd_q >= 9'h0A0) else $error("latch too soon after command");
   a_neg_to_ale: assert property (
      $fell(addrLatchN) |-> !cmdLow && sinceNeg_q >= 9'h010) else $error("latch over command");
   a_neg_to_cmd: assert property (
      $rose(cmdLow) |-> sinceNeg_q >= 9'h030) else $error("command recovery too short");
   a_same_class_gap: assert property (
      $rose(cmdLow) |-> sinceCmd_q >= 9'h0C0) else $error("commands too close");
   a_addr_to_cmd: assert property (
      $rose(cmdLow) |-> sinceAle_q >= 9'h050) else $error("address setup too short");
   a_ale_width: assert property (
      $rose(addrLatchN) |-> sinceAle_q >= 9'h050) else $error("latch released too soon");
   a_addr_stable: assert property (
      cmdLow |-> $stable({latchAddr, sysAddr, sysBhe})) else $error("address moved in command");
   a_ready_to_neg: assert property (
      $fell(cmdLow) |-> rdyCnt_q >= 9'h010) else $error("command ended without ready");
   a_wdata_setup: assert property (
      $rose(wrLow) |-> dataOe && sinceOe_q >= 9'h020) else $error("write data setup short");
   a_rsp_after_neg: assert property (
      $fell(cmdLow) |-> ##[0:16] rspValid) else $error("no answer after command");
   // Worst case is the 8-bit slave: 14T of upper address before ready may end it
   a_addr_to_end: assert property (
      $fell(cmdLow) |-> sinceAle_q >= 9'h0E0) else $error("address too late for ready");
   a_pins_on_bclk: assert property (
      ($rose(cmdLow) || $fell(cmdLow) || $changed(addrLatchN)) |-> $rose(busClk))
      else $error("strobe off bus clock edge");
   c_wait_stretch: cover property ($fell(cmdLow) && cmdLen_q > 9'h0A0);
   c_write: cover property ($rose(wrLow));
   c_back_to_back: cover property ($fell(addrLatchN) && sinceNeg_q < 9'h040);
endmodule
bind isam_master isam_master_properties i_props (.clk(clk), .nrst(nrst),
   .latchAddr(latchAddr), .sysAddr(sysAddr), .sysBhe(sysBhe), .addrLatchN(addrLatchN),
   .memRdN(memRdN), .memWrN(memWrN), .smemRdN(smemRdN), .smemWrN(smemWrN),
   .ioRdN(ioRdN), .ioWrN(ioWrN), .chanRdy(chanRdy), .dataOe(dataOe), .rspValid(rspValid),
   .busClk(busClk));
`default_nettype wire

// *** dv/isam_slave_model.sv ***
// Behavioural ISA slave: wait-state handshake and a small word memory
`default_nettype none
module isam_slave_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Bus side
   input  wire logic        rdN,
   input  wire logic        wrN,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic [7:0]  waitClk,
   output logic             chanRdy,
   output logic [15:0]      dataIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   logic [7:0]  waitCnt;
   logic        cmdSeen;
   logic        wrPrev;
   initial for (int i = 0; i < 16; i++) mem[i] = 16'h1111 * 16'(i);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chanRdy <= 1'b1;
         waitCnt <= 8'h00;
         cmdSeen <= 1'b0;
         wrPrev <= 1'b1;
         dataIn <= 16'h0000;
      end else begin
         cmdSeen <= !(rdN && wrN);
         wrPrev <= wrN;
         if (!(rdN && wrN) && !cmdSeen && waitClk != 8'h00) begin
            chanRdy <= 1'b0;
            waitCnt <= waitClk;
         end else if (waitCnt > 8'h01) begin
            waitCnt <= waitCnt - 8'h01;
         end else begin
            chanRdy <= 1'b1; // Pulled up once released
            waitCnt <= 8'h00;
         end
         // Floating lines toggle so stale data never looks valid
         dataIn <= !rdN ? mem[addr] : ~dataIn;
         if (wrN && !wrPrev) mem[addr] <= wdata;
      end
   end
endmodule
`default_nettype wire

// *** dv/tb_isam_master.sv ***
// Self-checking bench for the ISA bus master sequencer
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin errCount++; \
   $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_isam_master;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, nrst = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqByte = 1'b0;
   logic reqSbhe = 1'b0, reqReady, rspValid, busClk, sysBhe, addrLatchN, chanRdy, dataOe;
   logic memRdN, memWrN, smemRdN, smemWrN, ioRdN, ioWrN;
   logic [1:0]  reqClass = 2'h0;
   logic [23:0] reqAddr = 24'h000000;
   logic [15:0] reqWdata = 16'h0000, rspData, dataIn, dataOut;
   logic [6:0]  latchAddr;
   logic [19:0] sysAddr;
   logic [7:0]  waitClk = 8'h00;
   int errCount = 0, samplesChecked = 0, cycles = 0;
   int refMem [16];
   isam_master i_dut (.clk(clk), .nrst(nrst), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqClass(reqClass), .reqByte(reqByte), .reqAddr(reqAddr), .reqSbhe(reqSbhe),
      .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .busClk(busClk), .latchAddr(latchAddr), .sysAddr(sysAddr), .sysBhe(sysBhe),
      .addrLatchN(addrLatchN), .memRdN(memRdN), .memWrN(memWrN), .smemRdN(smemRdN),
      .smemWrN(smemWrN), .ioRdN(ioRdN), .ioWrN(ioWrN), .chanRdy(chanRdy), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe));
   isam_slave_model i_slave (.clk(clk), .nrst(nrst), .rdN(memRdN & smemRdN & ioRdN),
      .wrN(memWrN & smemWrN & ioWrN), .addr(sysAddr[3:0]), .wdata(dataOut),
      .waitClk(waitClk), .chanRdy(chanRdy), .dataIn(dataIn));
   always #4 clk = ~clk;
   task automatic stopTest();
      if (errCount == 0 && samplesChecked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         errCount++;
         stopTest();
      end
   end
   task automatic do_op(input logic wr, input logic [1:0] cls, input logic byt,
                        input logic [23:0] adr, input logic [15:0] wd, input logic [7:0] wt);
      int n;
      logic [5:0] seen;
      n = 0;
      seen = 6'h00;
      @(negedge clk);
      waitClk = wt;
      {reqWrite, reqClass, reqByte, reqAddr, reqSbhe, reqWdata} = {wr, cls, byt, adr, adr[0], wd};
      reqValid = 1'b1;
      while (reqReady !== 1'b1 && n < 500) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      reqValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 4000) begin
         @(posedge clk);
         #1;
         seen = seen | ~{memRdN, memWrN, smemRdN, smemWrN, ioRdN, ioWrN};
         n++;
      end
      if (n >= 4000) errCount++;
      // Exactly one strobe, picked by class and direction
      `CHK(seen, 6'h20 >> (2 * cls + wr))
      `CHK({latchAddr, sysBhe, sysAddr}, {adr[23:17], adr[0], adr[19:0]})
      // Slack of a few clocks covers tick alignment and ready synchronising
      `CHK(1'(n + 4 >= 80 + ((wt > 8'h80) ? int'(wt) + 16 : 144)), 1'b1)
      if (wr) refMem[adr[3:0]] = int'(wd);
      else `CHK(rspData, 16'(refMem[adr[3:0]]))
   endtask
   initial begin
      logic [23:0] a;
      int n;
      void'($urandom(32'hBB09));
      for (int i = 0; i < 16; i++) refMem[i] = 32'h1111 * i;
      repeat (12) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      // Every class and width, prompt and slow slaves, back to back
      for (int i = 0; i < 12; i++) begin
         a = 24'($urandom);
         do_op(1'b1, 2'(i % 3), i[1], a, 16'($urandom), 8'(i * 20));
         do_op(1'b0, 2'((i + 1) % 3), i[2], a, 16'h0000, 8'($urandom));
      end
      // Reset dropped in mid-command: strobes fall back at once
      @(negedge clk);
      reqValid = 1'b1;
      reqWrite = 1'b0;
      n = 0;
      while ((&{memRdN, smemRdN, ioRdN}) && n < 600) begin
         @(negedge clk);
         n++;
      end
      nrst = 1'b0;
      reqValid = 1'b0;
      #1;
      `CHK({addrLatchN, memRdN, smemRdN, ioRdN, reqReady, dataOe}, 6'h3C)
      `CHK(1'(n < 600), 1'b1)
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      do_op(1'b0, 2'h2, 1'b1, 24'h000005, 16'h0000, 8'h10);
      stopTest();
   end
endmodule
`undef CHK
`default_nettype wire
